/* File: i2c_fc_dev.sv */
// Function
// - data changes only while clock low
// - detect start and stop while clock high
// - only master makes start and stop
// - repeated start begins new transfer
// - eight-bit bytes, msb first, unlimited count
// - ninth clock: transmitter releases, receiver acknowledges
// - nack only on address mismatch
// - master ack makes slave release line
// - master nack makes slave send next byte
// - first byte: address plus direction bit
// - register address is one byte
// - register pointer advances, wraps 255 to 0
// - pointer auto-advances for consecutive writes and reads
// - registers move as two bytes, upper first
// - master writes start address before reading
// - pointer powers up at zero
// - frequency change within delay after upper write
// - works with bus clock up to 1 Mbit/s
// - factory mode: address from fixed code
// - pin mode: select pin picks address
// - 26-bit pull word in two registers
// - change starts only on upper word load
// - range register: four bits, rest zero
`timescale 1ns/100ps
module i2c_fc_dev #(
  parameter int         P_FREQ_DELAY_CYC = i2c_fc_pkg::FREQ_CHANGE_DELAY_CYC, // freq_change_delay in cycles
  parameter logic [3:0] P_FACTORY_CODE   = 4'h0,                              // factory address code
  parameter logic [3:0] P_RANGE_INIT     = 4'h0                               // factory pull range
) (
  input  wire logic                            I_CLK,                  // 100 MHz clock
  input  wire logic                            I_SYS_RST,              // synchronous reset, high
  input  wire logic                            I_CE,                   // clock enable
  input  wire logic                            I_ADDR_PIN_MODE,        // 1: pin-selected address
  input  wire logic                            I_ADDRESS_SELECT_PIN,   // address select pin
  output logic      [i2c_fc_pkg::WORD_W-1:0]   O_PULL_VALUE_WORD,      // applied pull word
  output logic      [i2c_fc_pkg::RANGE_W-1:0]  O_PULL_RANGE,           // pull range code
  output logic                                 O_FREQ_CHANGE,          // pulse: new word applied
  output logic                                 O_CHANGE_PENDING,       // upper word waiting for delay
  i2c_link_if.device                           LINK                    // two-wire bus
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_ADDR, S_RX, S_ACK_RX, S_TX, S_ACK_TX} dev_state_e;

  typedef struct packed {
    logic                            scl_m;
    logic                            scl_s;
    logic                            scl_d;
    logic                            sda_m;
    logic                            sda_s;
    logic                            sda_d;
    logic [1:0]                      sel_m;
    logic [1:0]                      sel_s;
    dev_state_e                      st;
    logic [3:0]                      bitcnt;
    logic [7:0]                      shreg;
    logic                            rw;
    logic                            have_ptr;
    logic                            lo_next;
    logic                            tx_lo;
    logic                            m_ack;
    logic [7:0]                      ptr;
    logic [7:0]                      hold;
    logic [15:0]                     txw;
    logic [15:0]                     lower;
    logic [i2c_fc_pkg::UPPER_W-1:0]  upper;
    logic [i2c_fc_pkg::RANGE_W-1:0]  range;
    logic                            sda_oe;
    logic                            pending;
    logic                            chg;
    logic [15:0]                     dcnt;
    logic [i2c_fc_pkg::WORD_W-1:0]   applied;
  } dev_s;

  dev_s        s;
  dev_s        next_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic [6:0]  own_addr;
  logic [15:0] rd_word;

  assign scl_rise   = s.scl_s & ~s.scl_d;
  assign scl_fall   = ~s.scl_s & s.scl_d;
  assign start_seen = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
  assign stop_seen  = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;

  // sel_s[1] is the mode strap, sel_s[0] the select pin
  assign own_addr = !s.sel_s[1] ? {i2c_fc_pkg::ADDR_FACTORY_HI, P_FACTORY_CODE} :
                    (s.sel_s[0] ? i2c_fc_pkg::ADDR_PIN_HIGH : i2c_fc_pkg::ADDR_PIN_LOW);

  // unmapped locations and unused bits read as zero
  assign rd_word = (s.ptr == i2c_fc_pkg::REG_LOWER) ? s.lower :
                   (s.ptr == i2c_fc_pkg::REG_UPPER) ? {{i2c_fc_pkg::UPPER_PAD{1'b0}}, s.upper} :
                   (s.ptr == i2c_fc_pkg::REG_RANGE) ? {{i2c_fc_pkg::RANGE_PAD{1'b0}}, s.range} :
                   16'h0000;

  always_comb begin
    next_s       = s;
    next_s.scl_m = LINK.scl;
    next_s.scl_s = s.scl_m;
    next_s.scl_d = s.scl_s;
    next_s.sda_m = LINK.sda;
    next_s.sda_s = s.sda_m;
    next_s.sda_d = s.sda_s;
    next_s.sel_m = {I_ADDR_PIN_MODE, I_ADDRESS_SELECT_PIN};
    next_s.sel_s = s.sel_m;
    next_s.chg   = 1'b0;

    // delayed frequency change after the upper word lands
    if (s.pending) begin
      if (s.dcnt == 16'h0000) begin
        next_s.pending = 1'b0;
        next_s.applied = {s.upper, s.lower};
        next_s.chg     = 1'b1;
      end else begin
        next_s.dcnt = s.dcnt - 16'h0001;
      end
    end

    if (start_seen) begin
      next_s.st       = S_ADDR;
      next_s.bitcnt   = 4'h0;
      next_s.sda_oe   = 1'b0;
      next_s.have_ptr = 1'b0;
      next_s.lo_next  = 1'b0;
    end else if (stop_seen) begin
      next_s.st     = S_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        S_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            next_s.shreg  = {s.shreg[6:0], s.sda_s};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == i2c_fc_pkg::BITS_PER_BYTE) begin
            if (s.st == S_ADDR) begin
              if (s.shreg[7:1] == own_addr) begin
                next_s.rw     = s.shreg[0];
                next_s.sda_oe = 1'b1;
                next_s.st     = S_ACK_ADDR;
              end else begin
                next_s.st = S_IDLE;
              end
            end else begin
              next_s.sda_oe = 1'b1;
              next_s.st     = S_ACK_RX;
              if (!s.have_ptr) begin
                next_s.ptr      = s.shreg;
                next_s.have_ptr = 1'b1;
              end else if (!s.lo_next) begin
                next_s.hold    = s.shreg;
                next_s.lo_next = 1'b1;
              end else begin
                next_s.lo_next = 1'b0;
                next_s.ptr     = s.ptr + 8'h01;
                unique case (s.ptr)
                  i2c_fc_pkg::REG_LOWER: next_s.lower = {s.hold, s.shreg};
                  i2c_fc_pkg::REG_UPPER: begin
                    next_s.upper   = {s.hold[1:0], s.shreg};
                    next_s.pending = 1'b1;
                    next_s.dcnt    = 16'(P_FREQ_DELAY_CYC - 1);
                  end
                  i2c_fc_pkg::REG_RANGE: next_s.range = s.shreg[3:0];
                  default: ;
                endcase
              end
            end
          end
        end
        S_ACK_ADDR, S_ACK_RX: begin
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.st == S_ACK_ADDR && s.rw) begin
              next_s.txw    = rd_word;
              next_s.ptr    = s.ptr + 8'h01;
              next_s.tx_lo  = 1'b0;
              next_s.shreg  = rd_word[15:8];
              next_s.sda_oe = ~rd_word[15];
              next_s.st     = S_TX;
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.st     = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (s.bitcnt == i2c_fc_pkg::LAST_DATA_BIT) begin
              next_s.sda_oe = 1'b0;
              next_s.st     = S_ACK_TX;
            end else begin
              next_s.shreg  = {s.shreg[6:0], 1'b0};
              next_s.sda_oe = ~s.shreg[6];
              next_s.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        S_ACK_TX: begin
          if (scl_rise) begin
            next_s.m_ack = ~s.sda_s;
          end else if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.m_ack) begin
              next_s.sda_oe = 1'b0;
              next_s.st     = S_IDLE;
            end else if (!s.tx_lo) begin
              next_s.tx_lo  = 1'b1;
              next_s.shreg  = s.txw[7:0];
              next_s.sda_oe = ~s.txw[7];
              next_s.st     = S_TX;
            end else begin
              next_s.txw    = rd_word;
              next_s.ptr    = s.ptr + 8'h01;
              next_s.tx_lo  = 1'b0;
              next_s.shreg  = rd_word[15:8];
              next_s.sda_oe = ~rd_word[15];
              next_s.st     = S_TX;
            end
          end
        end
        default: begin
          next_s.st     = S_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // oversampling at 100 MHz gives margin for a 1 MHz bus clock
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s       <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
      s.ptr   <= i2c_fc_pkg::PTR_INIT;
      s.lower <= i2c_fc_pkg::LOWER_INIT;
      s.upper <= i2c_fc_pkg::UPPER_INIT;
      s.range <= P_RANGE_INIT;
    end else if (I_CE) begin
      s <= next_s;
    end
  end

  assign LINK.dev_sda_o   = 1'b0;
  assign LINK.dev_sda_oe  = s.sda_oe;
  assign O_PULL_VALUE_WORD = s.applied;
  assign O_PULL_RANGE      = s.range;
  assign O_FREQ_CHANGE     = s.chg;
  assign O_CHANGE_PENDING  = s.pending;
endmodule // i2c_fc_dev

/* File: i2c_fc_host.sv */
`timescale 1ns/100ps
module cmd_fifo #(
  parameter int P_WIDTH = i2c_fc_pkg::CMD_W,      // word width
  parameter int P_DEPTH = i2c_fc_pkg::FIFO_DEPTH  // words held
) (
  input  wire logic               i_clk,       // clock
  input  wire logic               i_rst,       // synchronous reset
  input  wire logic               i_ce,        // clock enable
  input  wire logic               i_in_valid,  // word offered
  input  wire logic [P_WIDTH-1:0] i_in_data,   // word
  output logic                    o_in_ready,  // room left
  output logic                    o_out_valid, // word available
  output logic      [P_WIDTH-1:0] o_out_data,  // head word
  input  wire logic               i_out_ready  // drain side takes word
);
  localparam int AW = $clog2(P_DEPTH);

  typedef struct packed {
    logic [P_DEPTH-1:0][P_WIDTH-1:0] mem;
    logic [AW:0]                     wp;
    logic [AW:0]                     rp;
  } fifo_s;

  fifo_s s;
  fifo_s next_s;

  assign o_in_ready  = ~((s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]));
  assign o_out_valid = (s.wp != s.rp);
  assign o_out_data  = s.mem[s.rp[AW-1:0]];

  always_comb begin
    next_s = s;
    if (i_in_valid && o_in_ready) begin
      next_s.mem[s.wp[AW-1:0]] = i_in_data;
      next_s.wp                = s.wp + 1'b1;
    end
    if (o_out_valid && i_out_ready) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end
endmodule // cmd_fifo

module i2c_fc_host (
  input  wire logic                          I_CLK,       // 100 MHz clock
  input  wire logic                          I_SYS_RST,   // synchronous reset, high
  input  wire logic                          I_CE,        // clock enable
  input  wire logic                          I_CMD_VALID, // command offered
  input  wire logic [i2c_fc_pkg::CMD_W-1:0]  I_CMD,       // opcode and data
  output logic                               O_CMD_READY, // command queue has room
  output logic      [7:0]                    O_RD_DATA,   // last byte read
  output logic                               O_RD_VALID,  // read byte pulse
  output logic                               O_NACK,      // last written byte not acknowledged
  output logic                               O_BUSY,      // sequence in progress
  i2c_link_if.host                           LINK         // two-wire bus
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [1:0]  ph;
    logic [7:0]  qcnt;
    logic [3:0]  bitn;
    logic [1:0]  op;
    logic [7:0]  dat;
    logic [7:0]  sh;
    logic        scl_oe;
    logic        sda_oe;
    logic        scl_m;
    logic        scl_s;
    logic        sda_m;
    logic        sda_s;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        nack;
  } host_s;

  host_s                          s;
  host_s                          next_s;
  logic                           q_valid;
  logic [i2c_fc_pkg::CMD_W-1:0]   q_data;
  logic                           q_take;
  logic                           tick;

  cmd_fifo #(
    .P_WIDTH (i2c_fc_pkg::CMD_W),
    .P_DEPTH (i2c_fc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_rst       (I_SYS_RST),
    .i_ce        (I_CE),
    .i_in_valid  (I_CMD_VALID),
    .i_in_data   (I_CMD),
    .o_in_ready  (O_CMD_READY),
    .o_out_valid (q_valid),
    .o_out_data  (q_data),
    .i_out_ready (q_take)
  );

  assign q_take = (s.st == H_IDLE);
  assign tick   = (s.qcnt == 8'(i2c_fc_pkg::SCL_QUARTER_CYC - 1));

  always_comb begin
    next_s          = s;
    next_s.scl_m    = LINK.scl;
    next_s.scl_s    = s.scl_m;
    next_s.sda_m    = LINK.sda;
    next_s.sda_s    = s.sda_m;
    next_s.rd_valid = 1'b0;
    // wait while the clock line is held low by anyone else
    if (s.st != H_IDLE && !(s.ph == 2'h2 && !s.scl_s)) begin
      next_s.qcnt = tick ? 8'h00 : s.qcnt + 8'h01;
    end
    unique case (s.st)
      H_IDLE: begin
        if (q_valid) begin
          next_s.op   = q_data[9:8];
          next_s.dat  = q_data[7:0];
          next_s.sh   = q_data[7:0];
          next_s.bitn = 4'h0;
          next_s.ph   = 2'h0;
          next_s.qcnt = 8'h00;
          unique case (q_data[9:8])
            i2c_fc_pkg::CMD_START: next_s.st = H_START;
            i2c_fc_pkg::CMD_STOP:  next_s.st = H_STOP;
            default:               next_s.st = H_BIT;
          endcase
        end
      end
      H_START: if (tick) begin
        next_s.ph = s.ph + 2'h1;
        unique case (s.ph)
          2'h0: next_s.sda_oe = 1'b0;
          2'h1: next_s.scl_oe = 1'b0;
          2'h2: next_s.sda_oe = 1'b1;
          2'h3: begin
            next_s.scl_oe = 1'b1;
            next_s.op     = i2c_fc_pkg::CMD_WRITE;
            next_s.st     = H_BIT;
          end
        endcase
      end
      H_BIT: if (tick) begin
        next_s.ph = s.ph + 2'h1;
        unique case (s.ph)
          2'h0: begin
            if (s.bitn != i2c_fc_pkg::BITS_PER_BYTE) begin
              next_s.sda_oe = (s.op == i2c_fc_pkg::CMD_WRITE) ? ~s.sh[7] : 1'b0;
            end else begin
              next_s.sda_oe = (s.op == i2c_fc_pkg::CMD_WRITE) ? 1'b0 : ~s.dat[0];
            end
          end
          2'h1: next_s.scl_oe = 1'b0;
          2'h2: begin
            if (s.bitn != i2c_fc_pkg::BITS_PER_BYTE) begin
              next_s.sh = {s.sh[6:0], s.sda_s};
            end else if (s.op == i2c_fc_pkg::CMD_WRITE) begin
              next_s.nack = s.sda_s;
            end else begin
              next_s.rd_data  = s.sh;
              next_s.rd_valid = 1'b1;
            end
          end
          2'h3: begin
            next_s.scl_oe = 1'b1;
            next_s.bitn   = s.bitn + 4'h1;
            if (s.bitn == i2c_fc_pkg::BITS_PER_BYTE) begin
              next_s.st = H_IDLE;
            end
          end
        endcase
      end
      H_STOP: if (tick) begin
        next_s.ph = s.ph + 2'h1;
        unique case (s.ph)
          2'h0: next_s.sda_oe = 1'b1;
          2'h1: next_s.scl_oe = 1'b0;
          2'h2: next_s.sda_oe = 1'b0;
          2'h3: next_s.st     = H_IDLE;
        endcase
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s       <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
    end else if (I_CE) begin
      s <= next_s;
    end
  end

  assign LINK.host_scl_o  = 1'b0;
  assign LINK.host_sda_o  = 1'b0;
  assign LINK.host_scl_oe = s.scl_oe;
  assign LINK.host_sda_oe = s.sda_oe;
  assign O_RD_DATA        = s.rd_data;
  assign O_RD_VALID       = s.rd_valid;
  assign O_NACK           = s.nack;
  assign O_BUSY           = (s.st != H_IDLE) | q_valid;
endmodule // i2c_fc_host

/* File: i2c_fc_monitor.sv */
`timescale 1ns/100ps
module i2c_fc_monitor (
  input wire logic I_CLK,       // clock
  input wire logic I_SYS_RST,   // reset
  input wire logic scl,         // bus clock level
  input wire logic sda,         // bus data level
  input wire logic host_sda_oe, // host pulls data
  input wire logic dev_sda_oe   // device pulls data
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  chk_start_then_clock: assert property (s_start |-> ##[20:30] $fell(scl))
    else $error("no clock fall after start");
  chk_stop_bus_idle: assert property (s_stop |=> scl[*8])
    else $error("clock moved right after stop");
  chk_stop_dev_released: assert property (s_stop |=> (!dev_sda_oe)[*8])
    else $error("device drives data after stop");
  chk_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  chk_dev_bit_held: assert property ($rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda)[*8])
    else $error("device bit not held through clock high");
  chk_one_sender: assert property ($rose(scl) && dev_sda_oe |-> !host_sda_oe)
    else $error("both ends drive data");
  chk_clock_high_time: assert property ($rose(scl) |=> scl[*8])
    else $error("clock high phase too short");
  chk_clock_low_time: assert property ($fell(scl) |=> (!scl)[*8])
    else $error("clock low phase too short");
endmodule // i2c_fc_monitor

/* File: i2c_fc_pkg.sv */
package i2c_fc_pkg;

  // register map
  localparam logic [7:0] REG_LOWER = 8'h00;
  localparam logic [7:0] REG_UPPER = 8'h01;
  localparam logic [7:0] REG_RANGE = 8'h02;

  // field layout
  localparam int WORD_W   = 26;
  localparam int UPPER_W  = 10;
  localparam int RANGE_W  = 4;
  localparam int UPPER_PAD = 16 - UPPER_W;
  localparam int RANGE_PAD = 16 - RANGE_W;

  // reset values
  localparam logic [15:0] LOWER_INIT = 16'h0000;
  localparam logic [9:0]  UPPER_INIT = 10'h000;
  localparam logic [7:0]  PTR_INIT   = 8'h00;

  // device addresses and bit counts
  localparam logic [2:0] ADDR_FACTORY_HI = 3'h6;
  localparam logic [6:0] ADDR_PIN_LOW    = 7'h62;
  localparam logic [6:0] ADDR_PIN_HIGH   = 7'h6A;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT   = 4'h7;

  // timing
  localparam int CLK_PERIOD_NS         = 10;
  localparam int FREQ_CHANGE_DELAY_US  = 140;
  localparam int FREQ_CHANGE_DELAY_CYC = FREQ_CHANGE_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int SCL_RATE_KHZ          = 1000;
  localparam int SCL_QUARTER_CYC       = 1000000 / (SCL_RATE_KHZ * CLK_PERIOD_NS * 4);

  // host command stream: [9:8] opcode, [7:0] data
  localparam int         CMD_W      = 10;
  localparam int         FIFO_DEPTH = 16;
  localparam logic [1:0] CMD_START  = 2'h0;
  localparam logic [1:0] CMD_WRITE  = 2'h1;
  localparam logic [1:0] CMD_READ   = 2'h2;
  localparam logic [1:0] CMD_STOP   = 2'h3;

endpackage

/* File: i2c_link_if.sv */
`timescale 1ns/100ps
interface i2c_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain wired-and with pull-ups
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface // i2c_link_if

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  localparam int DLY = 50;
  logic        clk, rst, mode, sel, cmd_valid, cmd_ready, rd_valid, nack, busy, fchg, pend, full_seen;
  logic        scl_d, sda_d;
  logic [9:0]  cmd;
  logic [7:0]  rd_data;
  logic [25:0] word;
  logic [3:0]  range;
  logic [8:0]  sh;
  logic [7:0]  rdq[$];
  logic [8:0]  wq[$];
  logic [9:0]  tbl[6] = '{{2'h2, 7'h62, 1'h0}, {2'h2, 7'h6A, 1'h1}, {2'h3, 7'h6A, 1'h0},
                          {2'h3, 7'h62, 1'h1}, {2'h1, 7'h65, 1'h0}, {2'h0, 7'h62, 1'h1}};
  int          nb, pend_n, chg_n, cyc, n_fail, compares;

  i2c_link_if i2c_link_if_i ();
  i2c_fc_host i2c_fc_host_i (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'h1), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
    .O_CMD_READY(cmd_ready), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_NACK(nack), .O_BUSY(busy),
    .LINK(i2c_link_if_i.host));
  i2c_fc_dev #(.P_FREQ_DELAY_CYC(DLY), .P_FACTORY_CODE(4'h5)) i2c_fc_dev_i (.I_CLK(clk), .I_SYS_RST(rst),
    .I_CE(1'h1), .I_ADDR_PIN_MODE(mode), .I_ADDRESS_SELECT_PIN(sel), .O_PULL_VALUE_WORD(word),
    .O_PULL_RANGE(range), .O_FREQ_CHANGE(fchg), .O_CHANGE_PENDING(pend), .LINK(i2c_link_if_i.device));
  i2c_fc_monitor i2c_fc_monitor_i (.I_CLK(clk), .I_SYS_RST(rst), .scl(i2c_link_if_i.scl),
    .sda(i2c_link_if_i.sda), .host_sda_oe(i2c_link_if_i.host_sda_oe), .dev_sda_oe(i2c_link_if_i.dev_sda_oe));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // wire sniffer: 9 bits per frame, {byte, ack}
  always @(posedge clk) begin
    scl_d <= i2c_link_if_i.scl;
    sda_d <= i2c_link_if_i.sda;
    if (pend === 1'h1) pend_n <= pend_n + 1;
    if (fchg === 1'h1) chg_n <= chg_n + 1;
    if (rd_valid === 1'h1) rdq.push_back(rd_data);
    if (i2c_link_if_i.scl && scl_d && sda_d && !i2c_link_if_i.sda) nb <= 0;
    else if (i2c_link_if_i.scl && !scl_d) begin
      sh <= {sh[7:0], i2c_link_if_i.sda};
      nb <= (nb == 8) ? 0 : nb + 1;
      if (nb == 8) wq.push_back({sh[7:0], i2c_link_if_i.sda});
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic push(input logic [9:0] c);
    logic ok;
    cmd_valid = 1'h1;
    cmd = c;
    do begin
      ok = cmd_ready;
      if (ok !== 1'h1) full_seen = 1'h1;
      @(posedge clk);
      #1;
    end while (ok !== 1'h1);
  endtask

  // queue a whole sequence, then wait until the bus is idle again
  task automatic send(input logic [9:0] s[$]);
    foreach (s[i]) push(s[i]);
    cmd_valid = 1'h0;
    repeat (2) @(posedge clk);
    do begin
      @(posedge clk);
      #1;
    end while (busy !== 1'h0);
  endtask

  task automatic exp_rd(input logic [7:0] e[$]);
    check("read count", rdq.size(), e.size());
    foreach (e[i]) check("read byte", rdq[i], e[i]);
    rdq = {};
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    mode = 1'h1;
    sel = 1'h0;
    cmd_valid = 1'h0;
    cmd = 10'h000;
    full_seen = 1'h0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    repeat (4) @(posedge clk);
    #1;
    check("range", range, 4'h0);
    check("word", word, 26'h0000000);
    // read with no pointer written starts at location zero
    send('{10'h0C5, 10'h201, 10'h200, 10'h300});
    exp_rd('{8'h00, 8'h00});
    check("first frame", wq[0], {8'hC5, 1'h0});
    check("addr ack", nack, 1'h0);
    // pointer at 255, wrap to 0, then upper word, range, and read back after repeated starts
    send('{10'h0C4, 10'h1FF, 10'h1AA, 10'h1BB, 10'h112, 10'h134, 10'h103, 10'h156, 10'h1FF, 10'h1F7,
           10'h0C4, 10'h100, 10'h0C5, 10'h201, 10'h201, 10'h201, 10'h201, 10'h201, 10'h200, 10'h300});
    exp_rd('{8'h12, 8'h34, 8'h03, 8'h56, 8'h00, 8'h07});
    check("fifo refused", full_seen, 1'h1);
    check("word", word, 26'h3561234);
    check("range", range, 4'h7);
    check("changes", chg_n, 1);
    check("delay ok", (pend_n >= DLY - 2) && (pend_n <= DLY + 2), 1'h1);
    // lower word alone must not change the applied word
    send('{10'h0C4, 10'h100, 10'h1AB, 10'h1CD, 10'h0C4, 10'h100, 10'h0C5, 10'h201, 10'h200, 10'h300});
    exp_rd('{8'hAB, 8'hCD});
    check("word kept", word, 26'h3561234);
    check("changes", chg_n, 1);
    for (int i = 0; i < 6; i++) begin
      mode = tbl[i][9];
      sel = tbl[i][8];
      repeat (4) @(posedge clk);
      #1;
      send('{{2'h0, tbl[i][7:1], 1'h0}, 10'h102, 10'h300});
      check("addr nack", nack, tbl[i][0]);
    end
    check("ignored frame", wq[wq.size() - 1], {8'h02, 1'h1});
    check("idle bus", {i2c_link_if_i.scl, i2c_link_if_i.sda}, 2'h3);
    tally_and_finish();
  end
endmodule // tb
